// ==== src/lin_cfg_defines.vh ====
// Notes on behaviour
// (R1) A 16-bit frame 01_10011_P plus a settings byte writes the first channel's register.
// (R2) A 16-bit frame 01_10100_P plus a settings byte writes the second channel's register.
// (R3) Channel 1 bits 7:6 select 00 off, 01 unused, 10 off with wake-up, 11 transmit and receive.
// (R4) Channel 2 bits 7:6 use the same encoding as channel 1.
// (R5) Bits 5:4 pick the edge rate: 00 for 20 kbit/s, 01 for 10 kbit/s, 10 and 11 fast.
// (R6) Bit 2 turns the master termination on when set and off when clear.
// (R7) With bit 0 clear the channel goes recessive while the second supply is below about 6 V.
// (R8) With bit 0 set the channel keeps running below 6 V until the CAN supply regulator is off.
// (R9) Read frame bits 15:14 are 11 for failure flags or 00 for real-time levels or identity.
// (R10) Read frame bits 13:9 hold the address whose flags are wanted.
// (R11) Read frame bit 8 is one and is not treated as parity.
// (R12) The host sends the seven lowest read bits as zero; bit 7 picks one of two flag bytes.
// (R13) During a read the device returns a fixed status byte, then the requested flag byte.
// (R14) Bits 3 and 1 of a channel register are ignored on write.
`ifndef LIN_CFG_DEFINES_VH
`define LIN_CFG_DEFINES_VH

`define FRAME_BITS        5'h10
`define CMD_WRITE         2'h1
`define CMD_READ_FLAGS    2'h3
`define CMD_READ_LEVELS   2'h0
`define ADDR_LIN_CHANNEL1_CONFIG_CFG     5'h13
`define ADDR_LIN_CHANNEL2_CONFIG_CFG     5'h14
`define CFG_RESET         8'h00
`define CFG_WRITE_MASK    8'hF5
`define MODE_MSB          7
`define MODE_LSB          6
`define SLEW_MSB          5
`define SLEW_LSB          4
`define TERM_BIT          2
`define SUPPLY_EXT_BIT    0
`define MODE_OFF          2'h0
`define MODE_OFF_WAKE     2'h2
`define MODE_TXRX         2'h3
`define SLEW_20K          2'h0
`define SLEW_10K          2'h1
`define SLEW_FAST         2'h2
`define FLAG_SEL_BITS     5'h08

`endif

// ==== src/lin_channel_ctrl.v ====
`include "lin_cfg_defines.vh"

module lin_channel_ctrl (
   // clock and reset
   input  wire       clk_i,
   input  wire       rstn_i,
   // settings and supply state
   input  wire [7:0] cfg_i,
   input  wire       second_supply_low_i,
   input  wire       can_supply_regulator_on_i,
   // channel controls
   output reg        txrx_enable_o,
   output reg        wake_enable_o,
   output reg  [1:0] slew_sel_o,
   output reg        termination_enable_o,
   output reg        force_recessive_o
);

   wire [1:0] mode;
   wire [1:0] slew;

   assign mode = cfg_i[`MODE_MSB:`MODE_LSB];
   assign slew = cfg_i[`SLEW_MSB:`SLEW_LSB];

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         txrx_enable_o        <= 1'b0;
         wake_enable_o        <= 1'b0;
         slew_sel_o           <= `SLEW_20K;
         termination_enable_o <= 1'b0;
         force_recessive_o    <= 1'b0;
      end else begin
         // unused code 01 behaves as fully off
         txrx_enable_o        <= (mode == `MODE_TXRX);      // see (R3) see (R4)
         wake_enable_o        <= (mode == `MODE_OFF_WAKE);  // see (R3) see (R4)
         slew_sel_o           <= slew[1] ? `SLEW_FAST : slew; // see (R5)
         termination_enable_o <= cfg_i[`TERM_BIT];           // see (R6)
         if (!cfg_i[`SUPPLY_EXT_BIT])
            force_recessive_o <= second_supply_low_i;        // see (R7)
         else
            force_recessive_o <= second_supply_low_i &
                                 ~can_supply_regulator_on_i; // see (R8)
      end
   end

endmodule // lin_channel_ctrl

// ==== src/lin_cfg_spi.v ====
`include "lin_cfg_defines.vh"

module lin_cfg_spi (
   // clock and reset
   input  wire        clk_i,
   input  wire        rstn_i,
   // spi pins, sampled on clk_i
   input  wire        csb_n_i,
   input  wire        sclk_i,
   input  wire        mosi_i,
   output reg         miso_o,
   output reg         miso_oe_n_o,
   // flag source
   input  wire [7:0]  fixed_status_i,
   input  wire [15:0] flag_pair_i,
   output reg         flag_req_o,
   output reg  [1:0]  flag_kind_o,
   output reg  [4:0]  flag_addr_o,
   output reg         parity_error_o,
   // supply state
   input  wire        second_supply_low_i,
   input  wire        can_supply_regulator_on_i,
   // channel 1 controls
   output wire        ch1_txrx_enable_o,
   output wire        ch1_wake_enable_o,
   output wire [1:0]  ch1_slew_sel_o,
   output wire        channel1_termination_enable_o,
   output wire        ch1_force_recessive_o,
   // channel 2 controls
   output wire        ch2_txrx_enable_o,
   output wire        ch2_wake_enable_o,
   output wire [1:0]  ch2_slew_sel_o,
   output wire        channel2_termination_enable_o,
   output wire        ch2_force_recessive_o,
   // register contents
   output wire [7:0]  lin_channel1_config_o,
   output wire [7:0]  lin_channel2_config_o
);

   reg  [7:0]  lin_channel1_config_reg;
   reg  [7:0]  lin_channel2_config_reg;
   reg  [15:0] rx_reg;
   reg  [15:0] tx_reg;
   reg  [4:0]  count_reg;
   reg         sclk_q;
   reg         csb_q;
   reg         is_read_reg;

   wire        sclk_rise;
   wire        sclk_fall;
   wire        frame_start;
   wire        frame_end;
   wire [15:0] rx_next;
   wire [7:0]  flag_byte;

   function odd_parity;
      input [15:0] word;
      begin
         odd_parity = ^word;
      end
   endfunction

   function is_read_cmd;
      input [15:0] word;
      begin
         is_read_cmd = ((word[15:14] == `CMD_READ_FLAGS) ||
                        (word[15:14] == `CMD_READ_LEVELS)) && word[8]; // see (R9) see (R11)
      end
   endfunction

   assign sclk_rise   = ~csb_n_i & sclk_i & ~sclk_q;
   assign sclk_fall   = ~csb_n_i & ~sclk_i & sclk_q;
   assign frame_start = ~csb_n_i & csb_q;
   assign frame_end   = csb_n_i & ~csb_q;
   assign rx_next     = {rx_reg[14:0], mosi_i};
   // host has bit 7 on mosi by the falling edge after bit 8
   assign flag_byte   = mosi_i ? flag_pair_i[15:8] : flag_pair_i[7:0]; // see (R12)

   // bits 3 and 1 never reach a register
   function [7:0] kept_bits;
      input [7:0] data;
      begin
         kept_bits = data & `CFG_WRITE_MASK;                   // see (R14)
      end
   endfunction

   // decoded frame events
   wire        shift_in;
   wire        shift_out;
   wire        read_header;
   wire        flag_slot;
   wire        write_frame;
   wire        parity_ok;
   wire        write_ch1;
   wire        write_ch2;

   // a frame start wins over a coincident sclk edge
   assign shift_in    = sclk_rise & ~frame_start;
   assign shift_out   = sclk_fall & ~frame_start;
   // header complete after the eighth rise
   assign read_header = shift_in & (count_reg == 5'h07) &
                        is_read_cmd({rx_next[7:0], 8'h00});
   assign flag_slot   = (count_reg == `FLAG_SEL_BITS) & is_read_reg;
   // only full frames with the write prefix may commit
   assign write_frame = frame_end & (count_reg == `FRAME_BITS) &
                        (rx_reg[15:14] == `CMD_WRITE);
   assign parity_ok   = odd_parity(rx_reg);
   assign write_ch1   = write_frame & parity_ok &
                        (rx_reg[13:9] == `ADDR_LIN_CHANNEL1_CONFIG_CFG);   // see (R1)
   assign write_ch2   = write_frame & parity_ok &
                        (rx_reg[13:9] == `ADDR_LIN_CHANNEL2_CONFIG_CFG);   // see (R2)

   // pin history for edge detection
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_q <= 1'b0;
         csb_q  <= 1'b1;
      end else begin
         sclk_q <= sclk_i;
         csb_q  <= csb_n_i;
      end
   end

   // rising sclk count, saturating at a full frame
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_reg <= 5'h00;
      end else if (frame_start) begin
         count_reg <= 5'h00;
      end else if (shift_in && (count_reg != `FRAME_BITS)) begin
         count_reg <= count_reg + 5'h01;
      end
   end

   // mosi shift register, msb first
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_reg <= 16'h0000;
      end else if (shift_in) begin
         rx_reg <= rx_next;
      end
   end

   // read frame marker for the current frame
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         is_read_reg <= 1'b0;
      end else if (frame_start) begin
         is_read_reg <= 1'b0;
      end else if (read_header) begin
         is_read_reg <= 1'b1;
      end
   end

   // one pulse per read header
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_req_o <= 1'b0;
      end else begin
         flag_req_o <= read_header;
      end
   end

   // kind and address stand until the next read
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_kind_o <= 2'h0;
      end else if (read_header) begin
         flag_kind_o <= rx_next[7:6];                           // see (R9)
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_addr_o <= 5'h00;
      end else if (read_header) begin
         flag_addr_o <= rx_next[5:1];                           // see (R10)
      end
   end

   // miso driven only while selected
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         miso_oe_n_o <= 1'b1;
      end else if (frame_start) begin
         miso_oe_n_o <= 1'b0;
      end else if (frame_end) begin
         miso_oe_n_o <= 1'b1;
      end
   end

   // miso bit, changed on falling sclk
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         miso_o <= 1'b0;
      end else if (frame_start) begin
         miso_o <= fixed_status_i[7];                           // see (R13)
      end else if (frame_end) begin
         miso_o <= 1'b0;
      end else if (shift_out) begin
         if (flag_slot)
            miso_o <= flag_byte[7];                             // see (R13)
         else
            miso_o <= tx_reg[15];
      end
   end

   // bits still to send after the current one
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_reg <= 16'h0000;
      end else if (frame_start) begin
         tx_reg <= {fixed_status_i[6:0], 9'h000};
      end else if (shift_out) begin
         if (flag_slot)
            tx_reg <= {flag_byte[6:0], 9'h000};
         else
            tx_reg <= {tx_reg[14:0], 1'b0};
      end
   end

   // even parity discards the write
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         parity_error_o <= 1'b0;
      end else begin
         parity_error_o <= write_frame & ~parity_ok;
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lin_channel1_config_reg <= `CFG_RESET;
      end else if (write_ch1) begin
         lin_channel1_config_reg <= kept_bits(rx_reg[7:0]);    // see (R1) see (R14)
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lin_channel2_config_reg <= `CFG_RESET;
      end else if (write_ch2) begin
         lin_channel2_config_reg <= kept_bits(rx_reg[7:0]);    // see (R2) see (R14)
      end
   end

   assign lin_channel1_config_o = lin_channel1_config_reg;
   assign lin_channel2_config_o = lin_channel2_config_reg;

   lin_channel_ctrl u_ch1 (
      .clk_i                     (clk_i),
      .rstn_i                    (rstn_i),
      .cfg_i                     (lin_channel1_config_reg),
      .second_supply_low_i       (second_supply_low_i),
      .can_supply_regulator_on_i (can_supply_regulator_on_i),
      .txrx_enable_o             (ch1_txrx_enable_o),
      .wake_enable_o             (ch1_wake_enable_o),
      .slew_sel_o                (ch1_slew_sel_o),
      .termination_enable_o      (channel1_termination_enable_o),
      .force_recessive_o         (ch1_force_recessive_o)
   );

   lin_channel_ctrl u_ch2 (
      .clk_i                     (clk_i),
      .rstn_i                    (rstn_i),
      .cfg_i                     (lin_channel2_config_reg),
      .second_supply_low_i       (second_supply_low_i),
      .can_supply_regulator_on_i (can_supply_regulator_on_i),
      .txrx_enable_o             (ch2_txrx_enable_o),
      .wake_enable_o             (ch2_wake_enable_o),
      .slew_sel_o                (ch2_slew_sel_o),
      .termination_enable_o      (channel2_termination_enable_o),
      .force_recessive_o         (ch2_force_recessive_o)
   );

endmodule // lin_cfg_spi

// ==== verification/lin_cfg_props.sv ====
module lin_cfg_props (
   input wire logic       clk_i, rstn_i, csb_n_i, miso_o, miso_oe_n_o, flag_req_o,
   input wire logic       second_supply_low_i, can_supply_regulator_on_i,
   input wire logic       ch1_txrx_enable_o, ch1_force_recessive_o,
   input wire logic       ch2_wake_enable_o, channel2_termination_enable_o,
   input wire logic [1:0] flag_kind_o, ch1_slew_sel_o,
   input wire logic [7:0] lin_channel1_config_o, lin_channel2_config_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   wire [7:0] c1 = lin_channel1_config_o;
   wire [7:0] c2 = lin_channel2_config_o;
   a_ch1_txrx: assert property (ch1_txrx_enable_o == ($past(c1[7:6]) == 2'h3))
      else $error("ch1 txrx wrong");
   a_ch2_wake: assert property (ch2_wake_enable_o == ($past(c2[7:6]) == 2'h2))
      else $error("ch2 wake wrong");
   a_ch1_slew: assert property (ch1_slew_sel_o == ($past(c1[5]) ? 2'h2 : $past(c1[5:4])))
      else $error("ch1 slew wrong");
   a_ch2_term: assert property (channel2_termination_enable_o == $past(c2[2]))
      else $error("ch2 term wrong");
   a_ch1_recessive: assert property (ch1_force_recessive_o ==
      $past(second_supply_low_i & ~(c1[0] & can_supply_regulator_on_i)))
      else $error("ch1 recessive wrong");
   a_cfg_hold: assert property ($past(csb_n_i, 2) && $past(csb_n_i) && csb_n_i
      |-> $stable(c1) && $stable(c2)) else $error("config moved");
   a_bits_dropped: assert property (((c1 | c2) & 8'h0A) == 8'h00)
      else $error("bits 3 1 kept");
   a_req_pulse: assert property (flag_req_o |=> !flag_req_o) else $error("req too long");
   a_kind_legal: assert property (flag_req_o |=> flag_kind_o[1] == flag_kind_o[0])
      else $error("bad kind");
   a_oe_frame: assert property (miso_oe_n_o == $past(csb_n_i))
      else $error("oe wrong");
   a_idle_miso: assert property (miso_oe_n_o |-> !miso_o) else $error("miso not idle");
endmodule // lin_cfg_props
bind lin_cfg_spi lin_cfg_props u_props (.*);

// ==== verification/spi_host_model.sv ====
module spi_host_model (
   input  wire logic clk_i,
   input  wire logic miso_i,
   output logic      csb_n_o = 1'b1,
   output logic      sclk_o = 1'b0,
   output logic      mosi_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // msb first, sample on rise, next bit with the fall
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      csb_n_o = 1'b0;
      mosi_o = w[15];
      for (int i = 15; i >= 0; i--) begin
         wt(2);
         sclk_o = 1'b1;
         r[i] = miso_i;
         wt(2);
         sclk_o = 1'b0;
         mosi_o = (i > 0) ? w[i-1] : ~w[0];
      end
      wt(2);
      csb_n_o = 1'b1;
      wt(2);
   endtask
endmodule // spi_host_model

// ==== verification/tb_lin_cfg_spi.sv ====
module tb_lin_cfg_spi;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rstn_i = 0, low = 0, ron = 0, perr_seen = 0, sel;
   logic [7:0] status = 8'h00, m1, m2, d;
   logic [15:0] pair = 16'h0000, r;
   logic [1:0] kd;
   logic [4:0] a;
   wire csb, sclk, mosi, miso, oe_n, perr, req;
   wire [1:0] kind;
   wire [4:0] faddr;
   wire [5:0] ch1, ch2;
   wire [7:0] cfg1, cfg2;
   int error_cnt = 0, total_checks = 0, seed = 56154, req_cnt = 0;
   spi_host_model host (.clk_i(clk_i), .miso_i(miso), .csb_n_o(csb), .sclk_o(sclk),
      .mosi_o(mosi));
   lin_cfg_spi dut (.clk_i(clk_i), .rstn_i(rstn_i), .csb_n_i(csb), .sclk_i(sclk),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(oe_n), .fixed_status_i(status),
      .flag_pair_i(pair), .flag_req_o(req), .flag_kind_o(kind), .flag_addr_o(faddr),
      .parity_error_o(perr), .second_supply_low_i(low), .can_supply_regulator_on_i(ron),
      .ch1_txrx_enable_o(ch1[5]), .ch1_wake_enable_o(ch1[4]), .ch1_slew_sel_o(ch1[3:2]),
      .channel1_termination_enable_o(ch1[1]), .ch1_force_recessive_o(ch1[0]),
      .ch2_txrx_enable_o(ch2[5]), .ch2_wake_enable_o(ch2[4]), .ch2_slew_sel_o(ch2[3:2]),
      .channel2_termination_enable_o(ch2[1]), .ch2_force_recessive_o(ch2[0]),
      .lin_channel1_config_o(cfg1), .lin_channel2_config_o(cfg2));
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) perr_seen <= perr_seen | perr;
   always @(posedge clk_i) if (req === 1'b1) req_cnt <= req_cnt + 1;
   function automatic logic [5:0] exp_ch(input logic [7:0] c);
      return {c[7:6] == 2'h3, c[7:6] == 2'h2, c[5] ? 2'h2 : c[5:4], c[2], low & ~(c[0] & ron)};
   endfunction
   function automatic logic [15:0] wr(input logic [4:0] ad, input logic [7:0] v);
      logic [15:0] w;
      w = {2'h1, ad, 1'b0, v};
      w[8] = ~^w; // odd parity over the frame
      return w;
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      #1 rstn_i = 1;
      host.wt(2);
      check({cfg1, cfg2}, 16'h0000);
      m1 = 8'h00;
      m2 = 8'h00;
      for (int i = 0; i < 24; i++) begin
         d = $random(seed);
         if (i < 16) d[7:4] = i[3:0];
         low = $random(seed);
         ron = $random(seed);
         status = $random(seed);
         if (i[0]) begin
            host.xfer(wr(5'h13, d), r);
            m1 = d & 8'hF5;
         end else begin
            host.xfer(wr(5'h14, d), r);
            m2 = d & 8'hF5;
         end
         check({cfg1, cfg2}, {m1, m2});
         check(ch1, exp_ch(m1));
         check(ch2, exp_ch(m2));
         check(r, {status, 8'h00});
         check({oe_n, miso}, 2'h2);
      end
      check(req_cnt[15:0], 16'h0000);
      $display("test writes done");
      host.xfer(wr(5'h13, ~m1) ^ 16'h0100, r);
      host.xfer(wr(5'h15, ~m1), r);
      check({cfg1, cfg2}, {m1, m2});
      check(perr_seen, 1'b1);
      $display("test refusals done");
      for (int k = 0; k < 4; k++) begin
         sel = k[0];
         kd = k[1] ? 2'h3 : 2'h0;
         a = $random(seed);
         pair = $random(seed);
         status = $random(seed);
         host.xfer({kd, a, 1'b1, sel, 7'h00}, r);
         check(r, {status, sel ? pair[15:8] : pair[7:0]});
         check({kind, faddr}, {kd, a});
         check({cfg1, cfg2}, {m1, m2});
         check(req_cnt[15:0], k[15:0] + 16'h0001);
      end
      $display("test reads done");
      complete_run;
   end
endmodule // tb_lin_cfg_spi
